// file: chdf_consts.vh
`ifndef CHDF_CONSTS_VH
`define CHDF_CONSTS_VH
`define CHDF_DEPTH        32
`define CHDF_HALF_LEVEL   8
`define CHDF_REG_STATUS   8'h00
`define CHDF_REG_CLEAR    8'h04
`define CHDF_REG_CTRL     8'h08
`define CHDF_REG_TXDATA   8'h0C
`define CHDF_RXWIN_BASE   8'h80
`define CHDF_RXWIN_WORDS  32
`define CHDF_CTRL_TX_EN   0
`define CHDF_CTRL_RX_EN   1
`define CHDF_CTRL_DMA_EN  2
`define CHDF_CTRL_RESET   32'h0000_0000
`define CHDF_ST_TXF       0
`define CHDF_ST_TXE       1
`define CHDF_ST_TXHE      2
`define CHDF_ST_TX_DATA_AVAILABLE    3
`define CHDF_ST_TX_UNDERRUN_ERROR  4
`define CHDF_ST_RXF       5
`define CHDF_ST_RXE       6
`define CHDF_ST_RXHF      7
`define CHDF_ST_RX_DATA_AVAILABLE    8
`define CHDF_ST_RX_OVERRUN_ERROR   9
`define CHDF_ST_RECEIVE_ACTIVE     10
`define CHDF_CLR_UNDERR   4
`define CHDF_CLR_OVERR    9
`endif

// file: chdf_fifo.v
`timescale 1ns/1ps
`include "chdf_consts.vh"
// Operation
// - Card traffic is commands and responses; some operations add a data token.
// - SD/SDIO data moves in blocks; MMC data in blocks or streams.
// - Transmit full when all 32 transmit words hold data.
// - Transmit empty when no transmit word holds data.
// - Transmit half-empty when 8 or more words are free; DMA request.
// - Transmit data-available is the inverse of transmit empty.
// - Transmit underrun sets sticky flag until cleared by register write.
// - Received word is written, then write pointer advances.
// - Read data bus shows word at current read pointer on receive window reads; zero outside read acks.
// - Receive buffer disabled: flags low, both pointers held reset; a set overrun flag stays set until cleared by register write.
// - Receive-active asserted while data arrives from the card.
// - Receive buffer readable through 32 consecutive word addresses.
// - Receive full when all 32 receive words hold data.
// - Receive empty when no receive word holds data.
// - Receive half-full when 8 or more words hold data; DMA request.
// - Receive data-available is the inverse of receive empty while the receive buffer is enabled; both read low when disabled.
// - Receive overrun sets sticky flag until cleared by register write.
module chdf_fifo #(
  parameter DW = 32,
  parameter DEPTH = `CHDF_DEPTH,
  parameter AW = 5
) (
  input  wire          clock,
  input  wire          srst,
  input  wire [7:0]    wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  input  wire [3:0]    wb_sel_i,
  input  wire          wb_we_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire          link_clk,
  input  wire          link_rx_valid,
  input  wire [DW-1:0] link_rx_data,
  input  wire          link_tx_req,
  output reg  [DW-1:0] link_tx_data,
  output reg           link_tx_valid,
  output reg           tx_dma_req,
  output reg           rx_dma_req,
  output reg           receive_active
);
  // Constants cut to the count width on purpose
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [31:0] HALF_W  = `CHDF_HALF_LEVEL;
  localparam [AW:0] DEPTH_C = DEPTH_W[AW:0];
  localparam [AW:0] HALF_C  = HALF_W[AW:0];

  reg [DW-1:0] tx_mem [0:DEPTH-1];
  reg [DW-1:0] rx_mem [0:DEPTH-1];
  reg [AW-1:0] tx_wp_q;
  reg [AW-1:0] tx_rp_q;
  reg [AW-1:0] rx_wp_q;
  reg [AW-1:0] rx_rp_q;
  reg [AW:0]   tx_cnt_q;
  reg [AW:0]   rx_cnt_q;
  reg [AW:0]   tx_cnt_d;
  reg [AW:0]   rx_cnt_d;
  reg [31:0]   ctrl_q;
  reg          underr_q;
  reg          overr_q;
  reg [2:0]    clk_s_q;
  reg [1:0]    rxv_s_q;
  reg [1:0]    txr_s_q;
  reg [DW-1:0] rxd_s1_q;
  reg [DW-1:0] rxd_s2_q;
  reg [DW-1:0] rx_word_q;
  reg          rx_pend_q;
  reg [31:0]   status_w;
  reg [31:0]   rd_data_d;

  // Status decode shared by both buffers
  function [3:0] flags;
    input [AW:0] cnt;
    begin
      flags[0] = (cnt == DEPTH_C);
      flags[1] = (cnt == {(AW+1){1'b0}});
      flags[2] = (cnt >= HALF_C);
      flags[3] = ((DEPTH_C - cnt) >= HALF_C);
    end
  endfunction

  // Occupancy after one cycle; push and pop together leave it unchanged
  function [AW:0] next_count;
    input [AW:0] cnt;
    input        push;
    input        pop;
    begin
      next_count = cnt;
      if (push && !pop)
        next_count = cnt + 1'b1;
      else if (pop && !push)
        next_count = cnt - 1'b1;
    end
  endfunction

  wire       tx_en  = ctrl_q[`CHDF_CTRL_TX_EN];
  wire       rx_en  = ctrl_q[`CHDF_CTRL_RX_EN];
  wire       dma_en = ctrl_q[`CHDF_CTRL_DMA_EN];
  wire [3:0] tx_fl  = flags(tx_cnt_q);
  wire [3:0] rx_fl  = flags(rx_cnt_q);
  wire       tx_full  = tx_fl[0];
  wire       tx_empty = tx_fl[1];
  wire       tx_half_empty = tx_fl[3];
  wire       tx_avail = ~tx_empty;
  wire       rx_full  = rx_en & rx_fl[0];
  wire       rx_empty = rx_en & rx_fl[1];
  wire       rx_half_full = rx_en & rx_fl[2];
  wire       rx_avail = rx_en & ~rx_fl[1];

  // Link clock edge found from synchronised copy; stage 0 is read only by stage 1
  wire link_rise = clk_s_q[1] & ~clk_s_q[2];
  wire rx_strobe = link_rise & rxv_s_q[1];
  wire tx_strobe = link_rise & txr_s_q[1];

  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr    = bus_req & wb_we_i;
  wire bus_rd    = bus_req & ~wb_we_i;
  wire in_rxwin  = (wb_adr_i[7:2] >= (`CHDF_RXWIN_BASE >> 2)) &&
                   (wb_adr_i[7:2] < ((`CHDF_RXWIN_BASE >> 2) + `CHDF_RXWIN_WORDS));
  wire tx_push   = bus_wr && (wb_adr_i == `CHDF_REG_TXDATA) && tx_en && !tx_full;
  wire rx_pop    = bus_rd && in_rxwin && rx_en && !rx_empty;
  wire tx_pop    = tx_strobe && tx_en && !tx_empty;
  wire tx_under  = tx_strobe && tx_en && tx_empty;
  wire rx_push   = rx_pend_q && rx_en && !rx_full;
  wire rx_over   = rx_pend_q && rx_en && rx_full;
  wire clr_wr    = bus_wr && (wb_adr_i == `CHDF_REG_CLEAR) && wb_sel_i[1:0] != 2'h0;

  // One counting rule for both buffers
  always @* begin
    rx_cnt_d = next_count(rx_cnt_q, rx_push, rx_pop);
    tx_cnt_d = next_count(tx_cnt_q, tx_push, tx_pop);
  end

  always @(posedge clock) begin
    clk_s_q <= {clk_s_q[1:0], link_clk};
    rxv_s_q <= {rxv_s_q[0], link_rx_valid};
    txr_s_q <= {txr_s_q[0], link_tx_req};
  end

  // Word is held by the card around its clock edge, so the two-stage copy has settled
  always @(posedge clock) begin
    rxd_s1_q <= link_rx_data;
    rxd_s2_q <= rxd_s1_q;
  end

  // Word captured first, written the next cycle, pointer moves after write
  always @(posedge clock) begin
    if (srst) begin
      rx_pend_q <= 1'b0;
      rx_word_q <= {DW{1'b0}};
    end else begin
      rx_pend_q <= rx_strobe;
      if (rx_strobe)
        rx_word_q <= rxd_s2_q;
    end
  end

  always @(posedge clock) begin
    if (rx_push)
      rx_mem[rx_wp_q] <= rx_word_q;
  end

  // Writes to a full or disabled buffer are dropped without notice
  always @(posedge clock) begin
    if (tx_push)
      tx_mem[tx_wp_q] <= wb_dat_i;
  end

  always @(posedge clock) begin
    if (srst || !rx_en) begin
      rx_wp_q  <= {AW{1'b0}};
      rx_rp_q  <= {AW{1'b0}};
      rx_cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (rx_push)
        rx_wp_q <= rx_wp_q + 1'b1;
      if (rx_pop)
        rx_rp_q <= rx_rp_q + 1'b1;
      rx_cnt_q <= rx_cnt_d;
    end
  end

  // Pointers held at zero while disabled, so a re-enable starts clean
  always @(posedge clock) begin
    if (srst || !tx_en) begin
      tx_wp_q  <= {AW{1'b0}};
      tx_rp_q  <= {AW{1'b0}};
      tx_cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (tx_push)
        tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_pop)
        tx_rp_q <= tx_rp_q + 1'b1;
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // Sticky errors; a new event wins over a clear in the same cycle
  always @(posedge clock) begin
    if (srst)
      underr_q <= 1'b0;
    else if (tx_under)
      underr_q <= 1'b1;
    else if (clr_wr && wb_dat_i[`CHDF_CLR_UNDERR])
      underr_q <= 1'b0;
  end

  always @(posedge clock) begin
    if (srst)
      overr_q <= 1'b0;
    else if (rx_over)
      overr_q <= 1'b1;
    else if (clr_wr && wb_dat_i[`CHDF_CLR_OVERR])
      overr_q <= 1'b0;
  end

  always @(posedge clock) begin
    if (srst)
      ctrl_q <= `CHDF_CTRL_RESET;
    else if (bus_wr && wb_adr_i == `CHDF_REG_CTRL && wb_sel_i[0]) begin
      ctrl_q                    <= 32'h0000_0000;
      ctrl_q[`CHDF_CTRL_TX_EN]  <= wb_dat_i[`CHDF_CTRL_TX_EN];
      ctrl_q[`CHDF_CTRL_RX_EN]  <= wb_dat_i[`CHDF_CTRL_RX_EN];
      ctrl_q[`CHDF_CTRL_DMA_EN] <= wb_dat_i[`CHDF_CTRL_DMA_EN];
    end
  end

  // Unused status bits read as zero
  always @* begin
    status_w                    = 32'h0000_0000;
    status_w[`CHDF_ST_TXF]      = tx_full;
    status_w[`CHDF_ST_TXE]      = tx_empty;
    status_w[`CHDF_ST_TXHE]     = tx_half_empty;
    status_w[`CHDF_ST_TX_DATA_AVAILABLE]   = tx_avail;
    status_w[`CHDF_ST_TX_UNDERRUN_ERROR] = underr_q;
    status_w[`CHDF_ST_RXF]      = rx_full;
    status_w[`CHDF_ST_RXE]      = rx_empty;
    status_w[`CHDF_ST_RXHF]     = rx_half_full;
    status_w[`CHDF_ST_RX_DATA_AVAILABLE]   = rx_avail;
    status_w[`CHDF_ST_RX_OVERRUN_ERROR]  = overr_q;
    status_w[`CHDF_ST_RECEIVE_ACTIVE]    = receive_active;
  end

  // Window decoded first so no register offset can alias it
  always @* begin
    rd_data_d = 32'h0000_0000;
    if (in_rxwin)
      rd_data_d = rx_mem[rx_rp_q];
    else begin
      case (wb_adr_i)
        `CHDF_REG_STATUS: rd_data_d = status_w;
        `CHDF_REG_CTRL:   rd_data_d = ctrl_q;
        default:          rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  // Window reads pop in order; the offset within the window is not an index
  always @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_rd)
        wb_dat_o <= rd_data_d;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      link_tx_data  <= {DW{1'b0}};
      link_tx_valid <= 1'b0;
    end else begin
      link_tx_valid <= tx_pop;
      if (tx_pop)
        link_tx_data <= tx_mem[tx_rp_q];
    end
  end

  // Requests are registered levels; the DMA sees them one cycle after the count
  always @(posedge clock) begin
    if (srst) begin
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      tx_dma_req <= dma_en & tx_en & tx_half_empty;
      rx_dma_req <= dma_en & rx_half_full;
    end
  end

  always @(posedge clock) begin
    if (srst)
      receive_active <= 1'b0;
    else
      receive_active <= rx_en & (rxv_s_q[1] | rx_pend_q);
  end
endmodule

// file: chdf_fifo_checker.sv
`timescale 1ns/1ps
module chdf_chk (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        link_tx_valid,
  input wire logic        tx_dma_req,
  input wire logic        rx_dma_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Status fields are only meaningful while a status read is acked
  wire        st = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
  wire [31:0] s  = wb_dat_o;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  AST_ACK: assert property (s_req |=> s_ack) else $error("bus answer late");
  AST_DAT: assert property (!wb_ack_o |-> s == 32'h0) else $error("read data outside ack");
  AST_TXV: assert property (link_tx_valid |=> !link_tx_valid) else $error("tx valid long");
  AST_RST: assert property ($fell(srst) |-> !tx_dma_req && !rx_dma_req) else $error("dma on");
  AST_TX_AVAIL: assert property (st |-> s[3] == !s[1]) else $error("tx avail");
  AST_TX_FULL: assert property (st && s[0] |-> s[3] && !s[2]) else $error("tx full");
  AST_TX_EMPTY: assert property (st && s[1] |-> s[2] && !s[0]) else $error("tx empty");
  AST_RX_FULL: assert property (st && s[5] |-> s[7] && s[8]) else $error("rx full");
  AST_RX_EMPTY: assert property (st && s[6] |-> !s[7] && !s[8]) else $error("rx empty");
endmodule
bind chdf_fifo chdf_chk u_chk (.clock, .srst, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .link_tx_valid, .tx_dma_req, .rx_dma_req);

// file: chdf_card.sv
`timescale 1ns/1ps
module chdf_card (
  output logic        link_clk,
  output logic        link_rx_valid,
  output logic [31:0] link_rx_data,
  output logic        link_tx_req
);
  initial begin
    link_clk = 1'h0;
    link_rx_valid = 1'h0;
    link_rx_data = 32'h0;
    link_tx_req = 1'h0;
  end
  // Clock stands still between words; edges kept off the bus clock edges
  task automatic tick();
    #40 link_clk = 1'h1;
    #40 link_clk = 1'h0;
  endtask
  task automatic send(input logic [31:0] d);
    #2;
    link_rx_valid = 1'h1;
    link_rx_data = d;
    tick();
    link_rx_valid = 1'h0;
    link_rx_data = ~d; // Old word must not linger
    #78;
  endtask
  task automatic pull();
    #2;
    link_tx_req = 1'h1;
    tick();
    link_tx_req = 1'h0;
    #78;
  endtask
endmodule

// file: chdf_fifo_tb.sv
`timescale 1ns/1ps
module chdf_fifo_tb;
  logic        clock = 1'h0;
  logic        srst = 1'h1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        we = 1'h0;
  logic        stb = 1'h0;
  logic        act_seen = 1'h0;
  logic [31:0] rdat, ldat, rxw, rdq;
  logic        ack, lclk, rxv, txr, txv, txd, rxd, act;
  int          bad_count = 0;
  int          checks_done = 0;
  logic [31:0] got[$];
  logic [72:0] rows[5] = '{{8'h08, 1'h1, 32'h7, 32'h0}, {8'h08, 1'h0, 32'h0, 32'h7},
    {8'h10, 1'h1, 32'hFFFF_FFFF, 32'h0}, {8'h10, 1'h0, 32'h0, 32'h0},
    {8'h00, 1'h0, 32'h0, 32'h46}};
  always #5 clock = ~clock;
  always @(posedge clock) if (txv) got.push_back(ldat);
  always @(posedge clock) if (act) act_seen <= 1'h1;
  chdf_fifo u_chdf_fifo (.clock, .srst, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_clk(lclk), .link_rx_valid(rxv), .link_rx_data(rxw), .link_tx_req(txr),
    .link_tx_data(ldat), .link_tx_valid(txv), .tx_dma_req(txd), .rx_dma_req(rxd),
    .receive_active(act));
  chdf_card u_chdf_card (.link_clk(lclk), .link_rx_valid(rxv), .link_rx_data(rxw),
    .link_tx_req(txr));
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    adr <= a;
    we <= w;
    wdat <= d;
    stb <= 1'h1;
    do @(posedge clock); while (ack !== 1'h1);
    rdq = rdat;
    stb <= 1'h0;
  endtask
  task automatic st(input logic [31:0] e, input logic [1:0] d);
    wb(8'h00, 1'h0, 32'h0);
    chk("status", rdq, e);
    chk("dma", {30'h0, txd, rxd}, {30'h0, d});
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    foreach (rows[i]) begin
      wb(rows[i][72:65], rows[i][64], rows[i][63:32]);
      if (!rows[i][64]) chk("row", rdq, rows[i][31:0]);
    end
    srst <= 1'h1;
    repeat (2) @(posedge clock);
    srst <= 1'h0;
    st(32'h6, 2'h0);
    wb(8'h08, 1'h1, 32'h7);
    for (int i = 0; i < 33; i++) begin
      wb(8'h0C, 1'h1, 32'hA000_0000 + i);
      if (i == 23) st(32'h4C, 2'h2);
      if (i == 24) st(32'h48, 2'h0);
    end
    st(32'h49, 2'h0);
    repeat (32) u_chdf_card.pull();
    foreach (got[i]) chk("tx", got[i], 32'hA000_0000 + i);
    chk("txn", 32'(got.size()), 32'h20);
    st(32'h46, 2'h2);
    u_chdf_card.pull();
    st(32'h56, 2'h2);
    wb(8'h08, 1'h1, 32'h3);
    st(32'h56, 2'h0);
    wb(8'h04, 1'h1, 32'h10);
    st(32'h46, 2'h0);
    wb(8'h08, 1'h1, 32'h7);
    for (int i = 0; i < 33; i++) begin
      u_chdf_card.send(32'hB000_0000 + i);
      if (i == 6) st(32'h106, 2'h2);
      if (i == 7) st(32'h186, 2'h3);
    end
    st(32'h3A6, 2'h3);
    chk("active", {31'h0, act_seen}, 32'h1);
    wb(8'h08, 1'h1, 32'h3);
    for (int i = 0; i < 32; i++) begin
      wb(8'h80 + 8'(i * 4), 1'h0, 32'h0);
      chk("rx", rdq, 32'hB000_0000 + i);
    end
    st(32'h246, 2'h0);
    wb(8'h04, 1'h1, 32'h200);
    st(32'h46, 2'h0);
    wb(8'h08, 1'h1, 32'h1);
    st(32'h6, 2'h0);
    stop_test();
  end
endmodule
